/* core/scw_rx.sv */
// address-mark wakeup receiver with error flags and an axi4-lite slave
//
// Notes on behaviour
// - seven or eight info bits, then mark MSB.
// - sleep bit suppresses all receiver flags.
// - MSB-set character clears sleep by hardware.
// - sleep clears before stop bit; character kept.
// - overrun when character arrives while full.
// - overrun drops new character, keeps held one.
// - overrun clears by status then data read.
// - noise on any bit sets noise flag.
// - noise flag never shows before receive-full.
// - noise clears by error status, data read.
// - missing stop sets framing with receive-full.
// - framing plus overrun reports only overrun.
// - framing flag blocks further data transfers.
// - framing clears by status then data read.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`include "scw_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module scw_rx
  import scw_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        rxd,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256)
    $error("scw_rx: FIFO_DEPTH out of range");

  function automatic logic [7:0] scw_word(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic maj3(input logic a, b, c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic noisy3(input logic a, b, c);
    return !((a == b) && (b == c));
  endfunction

  // control state
  logic        ctrl_en;
  logic        ctrl_wls;
  logic        sleep;
  logic [15:0] baud_div;

  // status and data
  logic        receive_full_flag;
  logic        ovr;
  logic        nf;
  logic        fe;
  logic        arm_or;
  logic        arm_nf;
  logic        arm_fe;
  logic [8:0]  rx_data;

  // bus handshakes
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        stat_rd;
  logic        data_rd;
  logic        next_bvalid;
  logic        next_rvalid;
  logic        next_aw_got;
  logic        next_w_got;

  // line side
  logic        rxd_q;
  logic [15:0] baud_cnt;
  logic        tick;
  logic        s_a;
  logic        s_b;
  scw_state_t  state;
  logic [3:0]  os_cnt;
  logic [3:0]  bit_idx;
  logic [3:0]  last_idx;
  logic [8:0]  shift;
  logic        noise_acc;
  logic        bit_now;
  logic        bit_noisy;
  logic        at_mid;
  logic        at_end;
  logic        char_done;
  logic        wake;
  scw_char_t   new_char;
  logic        push_valid;
  logic        push_ready;
  logic        head_valid;
  logic        head_ready;
  scw_char_t   head;
  logic        take;

  // ---------------- bus slave ----------------
  assign aw_hs    = awvalid && awready;
  assign w_hs     = wvalid && wready;
  assign ar_hs    = arvalid && arready;
  assign do_write = (aw_got || aw_hs) && (w_got || w_hs);
  assign wr_addr  = aw_got ? aw_addr : awaddr;
  assign wr_data  = w_got ? w_data : wdata;
  assign wr_strb  = w_got ? w_strb : wstrb;
  assign stat_rd  = ar_hs && (scw_word(araddr) == `SCW_OFS_STAT);
  assign data_rd  = ar_hs && (scw_word(araddr) == `SCW_OFS_DATA);

  assign next_bvalid = do_write || (bvalid && !bready);
  assign next_rvalid = ar_hs || (rvalid && !rready);
  assign next_aw_got = (aw_got || aw_hs) && !do_write;
  assign next_w_got  = (w_got || w_hs) && !do_write;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `SCW_RESP_OKAY;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      // address and data are taken in either order, response after both
      awready <= !next_aw_got && !next_bvalid;
      wready  <= !next_w_got && !next_bvalid;
      bvalid  <= next_bvalid;
      if (aw_hs) begin
        aw_addr <= awaddr;
      end
      if (w_hs) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        unique case (scw_word(wr_addr))
          `SCW_OFS_CTRL, `SCW_OFS_BAUD,
          `SCW_OFS_STAT, `SCW_OFS_DATA: bresp <= `SCW_RESP_OKAY;
          default:                      bresp <= `SCW_RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SCW_RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_hs) begin
        rdata <= 32'h0000_0000;
        rresp <= `SCW_RESP_OKAY;
        unique case (scw_word(araddr))
          `SCW_OFS_CTRL: begin
            rdata[`SCW_CTRL_EN]    <= ctrl_en;
            rdata[`SCW_CTRL_WLS]   <= ctrl_wls;
            rdata[`SCW_CTRL_SLEEP] <= sleep;
          end
          `SCW_OFS_BAUD: rdata[15:0] <= baud_div;
          `SCW_OFS_STAT: begin
            rdata[`SCW_STAT_FULL]   <= receive_full_flag;
            rdata[`SCW_STAT_NOISE]  <= nf;
            rdata[`SCW_STAT_FRAME]  <= fe;
            rdata[`SCW_STAT_OVR]    <= ovr;
            rdata[`SCW_STAT_BUSY]   <= (state != SCW_IDLE);
            rdata[`SCW_STAT_QEMPTY] <= !head_valid;
          end
          `SCW_OFS_DATA: rdata[8:0] <= rx_data;
          default:       rresp <= `SCW_RESP_SLVERR;
        endcase
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {sleep, ctrl_wls, ctrl_en} <= `SCW_CTRL_RST;
      baud_div <= `SCW_BAUD_RST;
    end else begin
      if (do_write && scw_word(wr_addr) == `SCW_OFS_CTRL && wr_strb[0]) begin
        ctrl_en  <= wr_data[`SCW_CTRL_EN];
        ctrl_wls <= wr_data[`SCW_CTRL_WLS];
        sleep    <= wr_data[`SCW_CTRL_SLEEP];
      end else if (wake) begin
        sleep <= 1'b0;
      end
      if (do_write && scw_word(wr_addr) == `SCW_OFS_BAUD) begin
        if (wr_strb[0]) begin
          baud_div[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          baud_div[15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // ---------------- line sampling ----------------
  // tick runs at sixteen times the bit rate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (baud_cnt >= baud_div) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxd_q <= 1'b1;
      s_a   <= 1'b1;
      s_b   <= 1'b1;
    end else begin
      rxd_q <= rxd;
      if (tick && os_cnt == `SCW_SMP_A) begin
        s_a <= rxd_q;
      end
      if (tick && os_cnt == `SCW_SMP_B) begin
        s_b <= rxd_q;
      end
    end
  end

  // majority of three mid-bit samples, disagreement counts as noise
  assign bit_now   = maj3(s_a, s_b, rxd_q);
  assign bit_noisy = noisy3(s_a, s_b, rxd_q);
  assign at_mid    = tick && (os_cnt == `SCW_SMP_C);
  assign at_end    = tick && (os_cnt == `SCW_OS_LAST);
  assign last_idx  = ctrl_wls ? `SCW_IDX_M1 : `SCW_IDX_M0;

  // the mark bit is judged at its own mid-point, well before the stop bit
  assign wake = sleep && (state == SCW_DATA) && at_mid
              && (bit_idx == last_idx) && bit_now;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= SCW_IDLE;
      os_cnt    <= 4'h0;
      bit_idx   <= 4'h0;
      shift     <= 9'h000;
      noise_acc <= 1'b0;
    end else if (!ctrl_en) begin
      state <= SCW_IDLE;
    end else begin
      if (tick) begin
        os_cnt <= os_cnt + 4'h1;
      end
      unique case (state)
        SCW_IDLE: begin
          os_cnt <= 4'h0;
          if (tick && !rxd_q) begin
            state     <= SCW_START;
            os_cnt    <= 4'h1;
            bit_idx   <= 4'h0;
            shift     <= 9'h000;
            noise_acc <= 1'b0;
          end
        end
        SCW_START: begin
          if (at_mid) begin
            noise_acc <= bit_noisy;
            // a glitch that is not low at mid-bit is no start
            if (bit_now) begin
              state <= SCW_IDLE;
            end
          end
          if (at_end) begin
            state <= SCW_DATA;
          end
        end
        SCW_DATA: begin
          if (at_mid) begin
            shift[bit_idx] <= bit_now;
            noise_acc      <= noise_acc | bit_noisy;
          end
          if (at_end) begin
            if (bit_idx == last_idx) begin
              state <= SCW_STOP;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        SCW_STOP: begin
          // back to idle at mid stop bit to catch the next start early
          if (at_mid) begin
            state <= SCW_IDLE;
          end
        end
      endcase
    end
  end

  assign char_done      = (state == SCW_STOP) && at_mid;
  assign new_char.noise = noise_acc | bit_noisy;
  assign new_char.frame = !bit_now;
  assign new_char.data  = shift;
  // sleeping receiver queues nothing, so no flag can be set
  assign push_valid     = char_done && !sleep;

  scw_fifo #(
    .WIDTH ($bits(scw_char_t)),
    .DEPTH (FIFO_DEPTH)
  ) i_scw_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (new_char),
    .out_valid (head_valid),
    .out_ready (head_ready),
    .out_data  (head)
  );

  // ---------------- transfer into the data register ----------------
  // framing error stalls the queue; while asleep queued leftovers are dropped
  assign head_ready = sleep || !fe;
  assign take       = head_valid && !sleep && !fe;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_data <= 9'h000;
    end else if (take && !receive_full_flag) begin
      rx_data <= head.data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arm_or <= 1'b0;
      arm_nf <= 1'b0;
      arm_fe <= 1'b0;
    end else if (stat_rd) begin
      arm_or <= ovr;
      arm_nf <= ovr || nf || fe;
      arm_fe <= fe;
    end else if (data_rd) begin
      arm_or <= 1'b0;
      arm_nf <= 1'b0;
      arm_fe <= 1'b0;
    end
  end

  // each flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      receive_full_flag <= 1'b0;
    end else if (take && !receive_full_flag) begin
      receive_full_flag <= 1'b1;
    end else if (data_rd) begin
      receive_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovr <= 1'b0;
    end else if ((take && receive_full_flag) || (push_valid && !push_ready)) begin
      ovr <= 1'b1;
    end else if (data_rd && arm_or) begin
      ovr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nf <= 1'b0;
    end else if (take && !receive_full_flag && head.noise) begin
      nf <= 1'b1;
    end else if (data_rd && arm_nf) begin
      nf <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fe <= 1'b0;
    end else if (take && !receive_full_flag && head.frame) begin
      fe <= 1'b1;
    end else if (data_rd && arm_fe) begin
      fe <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* core/scw_cfg.svh */
// register map, field positions, reset values and sampling counts
`ifndef SCW_CFG_SVH
`define SCW_CFG_SVH

`define SCW_OFS_CTRL    8'h00
`define SCW_OFS_BAUD    8'h04
`define SCW_OFS_STAT    8'h08
`define SCW_OFS_DATA    8'h0C

`define SCW_CTRL_EN     0
`define SCW_CTRL_WLS    1
`define SCW_CTRL_SLEEP  2

`define SCW_STAT_FULL   0
`define SCW_STAT_NOISE  1
`define SCW_STAT_FRAME  2
`define SCW_STAT_OVR    3
`define SCW_STAT_BUSY   4
`define SCW_STAT_QEMPTY 5

`define SCW_CTRL_RST    3'h0
`define SCW_BAUD_RST    16'h0082

`define SCW_SMP_A       4'h7
`define SCW_SMP_B       4'h8
`define SCW_SMP_C       4'h9
`define SCW_OS_LAST     4'hF
`define SCW_IDX_M0      4'h7
`define SCW_IDX_M1      4'h8

`define SCW_RESP_OKAY   2'h0
`define SCW_RESP_SLVERR 2'h2

`endif

/* core/scw_pkg.sv */
// shared types of the serial receiver
package scw_pkg;

  typedef enum logic [1:0] {
    SCW_IDLE,
    SCW_START,
    SCW_DATA,
    SCW_STOP
  } scw_state_t;

  typedef struct packed {
    logic       noise;
    logic       frame;
    logic [8:0] data;
  } scw_char_t;

endpackage

/* core/scw_fifo.sv */
// small fifo with registered read data
`timescale 1ns/10ps
`default_nettype none

module scw_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("scw_fifo: DEPTH must be a power of two, at least 2");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             load;

  // count is sized one bit wider than the pointers so a full queue shows
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  // the output register refills as soon as it is empty or being drained
  assign load     = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (load) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* sim/scw_rx_checker.sv */
// bus protocol checks on the ports of the serial receiver
`include "scw_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module scw_rx_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |=> bvalid) else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_bresp_stands: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  a_rdata_stands: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_bad_addr: assert property (arvalid && arready
    && !(araddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
    |=> rresp == `SCW_RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ready_returns: assert property (bvalid && bready
    |=> !bvalid && awready && wready) else $error("write ready stuck");

  c_write: cover property (bvalid && bready);
  c_stat_read: cover property (arvalid && arready && araddr == 8'h08);
  c_bad_read: cover property (rvalid && rready && rresp == `SCW_RESP_SLVERR);
endmodule

`default_nettype wire

/* sim/scw_line_tx.sv */
// remote transmitter on the shared serial line, 16 clocks per bit
`timescale 1ns/10ps
`default_nettype none

module scw_line_tx (
  input  wire logic clk_sys,
  output var logic  rxd
);
  initial rxd = 1'b1;

  // a bad stop is low only in its first 11 clocks; the receiver, idle again from mid stop bit,
  // still sees the last low clock as a start and drops it as a glitch at its mid-bit
  task automatic send(input logic [8:0] val, input logic nine,
                      input logic bad_stop, input logic noisy);
    logic [10:0] fr;
    int          n;
    n = nine ? 11 : 10;
    fr = nine ? {1'b0, val, 1'b0} : {2'b10, val[7:0], 1'b0};
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk_sys);
        if (i == n - 1) begin
          rxd <= !(bad_stop && c < 11);
        end else begin
          rxd <= (noisy && i == 1 && c == 8) ? ~fr[i] : fr[i];
        end
      end
    end
    repeat (32) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

/* sim/scw_rx_test.sv */
// self-checking bench of the serial receiver
`include "scw_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module scw_rx_test;
  logic        clk_sys, rst, rxd, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          miscompares, samples_checked;

  scw_rx i_scw_rx (.clk_sys(clk_sys), .rst(rst), .rxd(rxd),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  scw_line_tx i_scw_line_tx (.clk_sys(clk_sys), .rxd(rxd));

  always #25 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    // answer is left waiting one edge so the slave must hold it
    bready <= 1'b1;
    @(posedge clk_sys);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    araddr <= a; arvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b1;
    @(posedge clk_sys);
    resp = rresp;
    rready <= 1'b0;
    check(rdata & m, e);
  endtask

  task automatic test_regs;
    rd_chk(`SCW_OFS_BAUD, 32'h0000_FFFF, 32'h0000_0082);
    rd_chk(`SCW_OFS_CTRL, 32'h0000_0007, 32'h0000_0000);
    rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    check({30'h0000_0000, resp}, {30'h0000_0000, `SCW_RESP_SLVERR});
    axi_wr(8'h14, 32'h0000_0001);
    check({30'h0000_0000, resp}, {30'h0000_0000, `SCW_RESP_SLVERR});
    axi_wr(`SCW_OFS_BAUD, 32'h0000_0000);
    axi_wr(`SCW_OFS_CTRL, 32'h0000_0001);
    $display("test registers done");
  endtask

  // second character has a bad stop and arrives while full
  task automatic test_overrun;
    i_scw_line_tx.send(9'h041, 1'b0, 1'b0, 1'b0);
    i_scw_line_tx.send(9'h042, 1'b0, 1'b1, 1'b0);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000D, 32'h0000_0009);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_0041);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0000);
    $display("test overrun done");
  endtask

  task automatic test_noise;
    i_scw_line_tx.send(9'h023, 1'b0, 1'b0, 1'b1);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0003);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_0023);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0000);
    $display("test noise done");
  endtask

  // data read without a status read first must leave framing set
  task automatic test_framing;
    i_scw_line_tx.send(9'h055, 1'b0, 1'b1, 1'b0);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_0055);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000D, 32'h0000_0004);
    i_scw_line_tx.send(9'h066, 1'b0, 1'b0, 1'b0);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000D, 32'h0000_0004);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_0055);
    repeat (8) @(posedge clk_sys);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0001);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_0066);
    $display("test framing done");
  endtask

  // nine-bit characters: mark bit is bit 8
  task automatic test_sleep;
    axi_wr(`SCW_OFS_CTRL, 32'h0000_0007);
    i_scw_line_tx.send(9'h0AA, 1'b1, 1'b0, 1'b0);
    i_scw_line_tx.send(9'h02A, 1'b1, 1'b1, 1'b0);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0000);
    rd_chk(`SCW_OFS_CTRL, 32'h0000_0007, 32'h0000_0007);
    i_scw_line_tx.send(9'h1B5, 1'b1, 1'b0, 1'b0);
    rd_chk(`SCW_OFS_CTRL, 32'h0000_0007, 32'h0000_0003);
    rd_chk(`SCW_OFS_STAT, 32'h0000_000F, 32'h0000_0001);
    rd_chk(`SCW_OFS_DATA, 32'h0000_01FF, 32'h0000_01B5);
    $display("test sleep done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0; rst = 1'b1; awaddr = 8'h00; awvalid = 1'b0;
    wdata = 32'h0000_0000; wstrb = 4'hF; wvalid = 1'b0; bready = 1'b0;
    araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    test_regs;
    test_overrun;
    test_noise;
    test_framing;
    test_sleep;
    report_and_stop;
  end

  // the whole run needs about 1700 cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    report_and_stop;
  end
endmodule

bind scw_rx scw_rx_checker i_scw_rx_checker (.clk_sys(clk_sys), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready));

`default_nettype wire
